// ===== rtl/mbx_defines.vh
// Address map, bank pool and cache geometry constants for the memory block
`ifndef MBX_DEFINES_VH
`define MBX_DEFINES_VH
// Address space: 16 regions of 1 MB in a 24-bit space
`define MBX_ADDR_W 24
`define MBX_REGION_COUNT 16
`define MBX_REGION_BYTES 24'h100000
// Region numbers (top address nibble)
`define MBX_REG_INSTR 4'h0
`define MBX_REG_DATA 4'h2
`define MBX_REG_XIP_LO 4'h4
`define MBX_REG_XIP_HI 4'hB
`define MBX_REG_DIR 4'hC
`define MBX_REG_PERIPH 4'hF
// Instruction area layout (offsets inside the region)
`define MBX_ROM_BYTES 20'h24000
`define MBX_IFIX_BASE 20'h24000
`define MBX_IFIX_END 20'h28000
`define MBX_IBANK_BASE 20'h28000
// Data area layout
`define MBX_DFIX_END 20'h04000
`define MBX_DBANK_BASE 20'h04000
// Configurable bank pool
`define MBX_BANK_COUNT 7
`define MBX_BANK_SHIFT 15
`define MBX_BANK_NONE 3'h7
`define MBX_CACHE_BANK 3'h6
// Bank state encodings
`define MBX_BANK_OFF 2'h0
`define MBX_BANK_INSTR 2'h1
`define MBX_BANK_DATA 2'h2
`define MBX_BANK_CACHE 2'h3
// Cache geometry: 32 KB, 2 ways, 64-byte lines, 8 MB window
`define MBX_WAYS 2
`define MBX_SETS 256
`define MBX_LINE_WORDS 16
`define MBX_TAG_W 9
`define MBX_CRAM_AW 13
`define MBX_LAST_WORD 4'hF
`endif

// ===== rtl/mbx_mem_cache.v
// Memory map decoder, RAM bank pool control and execute-in-place read cache
`timescale 1ns/1ps
`include "mbx_defines.vh"
module mbx_mem_cache (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Boot strap and static configuration
  input wire hostBootSelectPad,
  input wire fwCacheEnable,
  input wire [13:0] bankCfg,
  // Instruction fetch port
  input wire ifReq,
  input wire [23:0] ifAddr,
  output reg ifReady_q,
  output reg ifValid_q,
  output reg ifErr_q,
  output reg [31:0] ifData_q,
  output reg [8:0] iTcmSel_q,
  output reg [19:0] iTcmAddr_q,
  // Data load/store port
  input wire dReq,
  input wire dWe,
  input wire [23:0] dAddr,
  input wire [31:0] dWdata,
  output reg dValid_q,
  output reg dErr_q,
  output reg [31:0] dRdata_q,
  output reg [7:0] dTcmSel_q,
  output reg [19:0] dTcmAddr_q,
  output reg dTcmWe_q,
  output reg [31:0] dTcmWdata_q,
  output reg periphSel_q,
  output reg [19:0] periphAddr_q,
  // Bank power and mode status
  output reg [6:0] bankPowerOn_q,
  output reg cacheActive_q,
  output reg flashRandomAllow_q,
  // Cache storage bank port
  output reg cacheRamRd_q,
  output reg cacheRamWe_q,
  output reg [12:0] cacheRamAddr_q,
  output reg [31:0] cacheRamWdata_q,
  input wire [31:0] cacheRamRdata,
  // Line fetch toward the quad SPI flash engine
  output reg flashReq_q,
  output reg [22:0] flashAddr_q,
  input wire flashAck,
  input wire flashWordValid,
  input wire [31:0] flashWord
);

  // Fetch FSM states
  localparam S_IDLE = 3'h0;
  localparam S_LOOK = 3'h1;
  localparam S_RAMWT = 3'h2;
  localparam S_RAMDATA = 3'h3;
  localparam S_FILL = 3'h4;
  localparam S_DONE = 3'h5;

  // Bank index for an offset inside an area, or none
  function [2:0] bankOf;
    input [19:0] off;
    input [19:0] base;
    reg [19:0] rel;
    begin
      rel = off - base;
      if (off < base || rel[19:`MBX_BANK_SHIFT] >= `MBX_BANK_COUNT) begin
        bankOf = `MBX_BANK_NONE;
      end else begin
        bankOf = rel[17:15];
      end
    end
  endfunction

  // Bank usable in an area: matching state, and not lent to the cache
  function bankUsable;
    input [2:0] idx;
    input [1:0] want;
    input [13:0] cfg;
    input cacheOn;
    reg [1:0] st;
    begin
      st = cfg[{idx, 1'b0} +: 2];
      bankUsable = (idx != `MBX_BANK_NONE) && (st == want) &&
        !(cacheOn && idx == `MBX_CACHE_BANK);
    end
  endfunction

  // Tag directory: valid bit above a 9-bit tag, per way and set
  reg [9:0] tagWay0 [0:255];
  reg [9:0] tagWay1 [0:255];
  // Per set: way used most recently, victim is the other
  reg [255:0] lruWay_q;
  reg [2:0] state_q;
  reg [22:0] reqAddr_q; // Flash-window address of the pending miss
  reg fillWay_q;
  reg [3:0] fillCnt_q;
  reg strapDone_q; // Strap sampled once after reset release
  reg host_boot_select_pad_q;
  integer i, j; // Loop indices, one per process so each has a single driver

  // Decode of the incoming fetch address
  wire [3:0] ifRegion = ifAddr[23:20];
  wire [19:0] ifOff = ifAddr[19:0];
  wire [2:0] ifBank = bankOf(ifOff, `MBX_IBANK_BASE);
  wire ifInXip = (ifRegion >= `MBX_REG_XIP_LO) && (ifRegion <= `MBX_REG_XIP_HI);
  // Decode of the incoming data address
  wire [3:0] dRegion = dAddr[23:20];
  wire [19:0] dOff = dAddr[19:0];
  wire [2:0] dBank = bankOf(dOff, `MBX_DBANK_BASE);
  // Lookup of the pending miss address
  wire [7:0] lkIdx = reqAddr_q[13:6];
  wire [8:0] lkTag = reqAddr_q[22:14];
  wire [9:0] lkE0 = tagWay0[lkIdx];
  wire [9:0] lkE1 = tagWay1[lkIdx];
  wire hit0 = lkE0[9] && (lkE0[8:0] == lkTag);
  wire hit1 = lkE1[9] && (lkE1[8:0] == lkTag);
  // Cache needs its bank set to cache state to run
  wire cacheEnNow = (strapDone_q && !host_boot_select_pad_q) || fwCacheEnable;
  wire cacheBankOk = bankCfg[13:12] == `MBX_BANK_CACHE;

  // Strap capture, mode status and bank power
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      strapDone_q <= 1'b0;
      host_boot_select_pad_q <= 1'b1;
      cacheActive_q <= 1'b0;
      flashRandomAllow_q <= 1'b0;
      bankPowerOn_q <= 7'h00;
    end else begin
      // Pad read on first edge after release, then frozen
      if (!strapDone_q) begin
        strapDone_q <= 1'b1;
        host_boot_select_pad_q <= hostBootSelectPad;
      end
      cacheActive_q <= cacheEnNow && cacheBankOk;
      // Random flash commands locked out while the cache owns flash
      flashRandomAllow_q <= strapDone_q && !(cacheEnNow && cacheBankOk);
      for (j = 0; j < 7; j = j + 1) begin
        bankPowerOn_q[j] <= bankCfg[2*j +: 2] != `MBX_BANK_OFF;
      end
    end
  end

  // Fetch path, data path and cache directory share one process,
  // since the directory has a single writer
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= S_IDLE;
      ifReady_q <= 1'b0;
      ifValid_q <= 1'b0;
      ifErr_q <= 1'b0;
      ifData_q <= 32'h00000000;
      iTcmSel_q <= 9'h000;
      iTcmAddr_q <= 20'h00000;
      dValid_q <= 1'b0;
      dErr_q <= 1'b0;
      dRdata_q <= 32'h00000000;
      dTcmSel_q <= 8'h00;
      dTcmAddr_q <= 20'h00000;
      dTcmWe_q <= 1'b0;
      dTcmWdata_q <= 32'h00000000;
      periphSel_q <= 1'b0;
      periphAddr_q <= 20'h00000;
      cacheRamRd_q <= 1'b0;
      cacheRamWe_q <= 1'b0;
      cacheRamAddr_q <= 13'h0000;
      cacheRamWdata_q <= 32'h00000000;
      flashReq_q <= 1'b0;
      flashAddr_q <= 23'h000000;
      reqAddr_q <= 23'h000000;
      fillWay_q <= 1'b0;
      fillCnt_q <= 4'h0;
      lruWay_q <= 256'h0;
      for (i = 0; i < 256; i = i + 1) begin
        tagWay0[i] <= 10'h000;
        tagWay1[i] <= 10'h000;
      end
    end else begin
      // Pulses default low
      ifValid_q <= 1'b0;
      ifErr_q <= 1'b0;
      iTcmSel_q <= 9'h000;
      dValid_q <= 1'b0;
      dErr_q <= 1'b0;
      dTcmSel_q <= 8'h00;
      dTcmWe_q <= 1'b0;
      periphSel_q <= 1'b0;
      cacheRamRd_q <= 1'b0;
      cacheRamWe_q <= 1'b0;
      // Data port: one request per cycle, answered next cycle
      if (dReq) begin
        dTcmAddr_q <= dOff;
        dTcmWdata_q <= dWdata;
        periphAddr_q <= dOff;
        if (dRegion == `MBX_REG_DATA && dOff < `MBX_DFIX_END) begin
          dTcmSel_q <= 8'h01;
          dTcmWe_q <= dWe;
          dTcmAddr_q <= dOff;
        end else if (dRegion == `MBX_REG_DATA &&
                     bankUsable(dBank, `MBX_BANK_DATA, bankCfg, cacheActive_q)) begin
          dTcmSel_q <= 8'h02 << dBank;
          dTcmWe_q <= dWe;
          dTcmAddr_q <= {5'h00, dOff[14:0] - 15'h4000};
        end else if (dRegion == `MBX_REG_PERIPH) begin
          periphSel_q <= 1'b1;
        end else if (dRegion == `MBX_REG_DIR) begin
          // Way in bit 10, set in bits 9:2; any write with the cache inactive invalidates
          if (dWe && !cacheActive_q) begin
            if (dOff[10]) begin
              tagWay1[dOff[9:2]] <= 10'h000;
            end else begin
              tagWay0[dOff[9:2]] <= 10'h000;
            end
            dValid_q <= 1'b1;
          end else if (dWe) begin
            dErr_q <= 1'b1; // Directory frozen while cache runs
          end else begin
            dRdata_q <= {22'h000000, dOff[10] ? tagWay1[dOff[9:2]] : tagWay0[dOff[9:2]]};
            dValid_q <= 1'b1;
          end
        end else begin
          // Unmapped, instruction area, or read-only flash window
          dErr_q <= 1'b1;
        end
      end
      // Fetch FSM
      case (state_q)
        S_IDLE: begin
          ifReady_q <= 1'b1;
          if (ifReq && ifReady_q) begin
            iTcmAddr_q <= ifOff;
            if (ifRegion == `MBX_REG_INSTR && ifOff < `MBX_ROM_BYTES) begin
              iTcmSel_q <= 9'h001;
            end else if (ifRegion == `MBX_REG_INSTR && ifOff < `MBX_IFIX_END) begin
              iTcmSel_q <= 9'h002;
              iTcmAddr_q <= ifOff - `MBX_IFIX_BASE;
            end else if (ifRegion == `MBX_REG_INSTR &&
                         bankUsable(ifBank, `MBX_BANK_INSTR, bankCfg, cacheActive_q)) begin
              iTcmSel_q <= 9'h004 << ifBank;
              iTcmAddr_q <= {5'h00, ifOff[14:0]};
            end else if (ifInXip && cacheActive_q) begin
              // 8 MB window: region offset from the window base
              reqAddr_q <= ifAddr[22:0] - 23'h400000;
              ifReady_q <= 1'b0;
              state_q <= S_LOOK;
            end else begin
              ifErr_q <= 1'b1;
            end
          end
        end
        S_LOOK: begin
          if (hit0 || hit1) begin
            cacheRamRd_q <= 1'b1;
            cacheRamAddr_q <= {hit1, lkIdx, reqAddr_q[5:2]};
            lruWay_q[lkIdx] <= hit1;
            state_q <= S_RAMWT;
          end else begin
            // Victim is the way not used most recently
            fillWay_q <= ~lruWay_q[lkIdx];
            fillCnt_q <= 4'h0;
            flashReq_q <= 1'b1;
            flashAddr_q <= {reqAddr_q[22:6], 6'h00};
            if (lruWay_q[lkIdx]) begin
              tagWay0[lkIdx] <= 10'h000;
            end else begin
              tagWay1[lkIdx] <= 10'h000;
            end
            state_q <= S_FILL;
          end
        end
        S_RAMWT: begin
          state_q <= S_RAMDATA; // Storage bank answers one cycle after read
        end
        S_RAMDATA: begin
          ifData_q <= cacheRamRdata;
          ifValid_q <= 1'b1;
          state_q <= S_DONE;
        end
        S_FILL: begin
          if (flashAck) begin
            flashReq_q <= 1'b0;
          end
          if (flashWordValid) begin
            cacheRamWe_q <= 1'b1;
            cacheRamAddr_q <= {fillWay_q, lkIdx, fillCnt_q};
            cacheRamWdata_q <= flashWord;
            // Requested word forwarded from the fill stream
            if (fillCnt_q == reqAddr_q[5:2]) begin
              ifData_q <= flashWord;
            end
            fillCnt_q <= fillCnt_q + 4'h1;
            if (fillCnt_q == `MBX_LAST_WORD) begin
              if (fillWay_q) begin
                tagWay1[lkIdx] <= {1'b1, lkTag};
              end else begin
                tagWay0[lkIdx] <= {1'b1, lkTag};
              end
              lruWay_q[lkIdx] <= fillWay_q;
              ifValid_q <= 1'b1;
              state_q <= S_DONE;
            end
          end
        end
        S_DONE: begin
          ifReady_q <= 1'b1;
          state_q <= S_IDLE;
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end

endmodule

// ===== testbench/mbx_mem_cache_assertions.sv
// Concurrent checks on the memory map and read cache ports
`timescale 1ns/1ps
module mbx_mem_cache_assertions (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Configuration
  input wire [13:0] bankCfg,
  // Fetch port
  input wire ifReq,
  input wire [23:0] ifAddr,
  input wire ifReady_q,
  input wire ifValid_q,
  input wire ifErr_q,
  input wire [8:0] iTcmSel_q,
  input wire [19:0] iTcmAddr_q,
  // Data port
  input wire dReq,
  input wire dWe,
  input wire [23:0] dAddr,
  input wire dErr_q,
  input wire [7:0] dTcmSel_q,
  input wire periphSel_q,
  input wire [19:0] periphAddr_q,
  // Status and flash side
  input wire [6:0] bankPowerOn_q,
  input wire cacheActive_q,
  input wire flashRandomAllow_q,
  input wire cacheRamWe_q,
  input wire flashReq_q,
  input wire [22:0] flashAddr_q,
  input wire flashAck,
  input wire flashWordValid
);
  default clocking dc @(posedge clk); endclocking
  default disable iff (!rst_n);
  reg [3:0] wordCnt_q; // Words seen in the current fill
  wire [6:0] pwrExp; // Banks that should be powered
  // Fill counter restarts on each accepted line request
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) wordCnt_q <= 4'h0;
    else if (flashAck) wordCnt_q <= 4'h0;
    else if (flashWordValid) wordCnt_q <= wordCnt_q + 4'h1;
  end
  genvar g;
  for (g = 0; g < 7; g++) begin : gPwr
    assign pwrExp[g] = |bankCfg[2*g+:2];
  end
  sequence fillDone; flashWordValid && wordCnt_q == 4'hF; endsequence
  sequence answerSoon; ##[1:3] ifValid_q; endsequence
  sequence romTake; ifReq && ifReady_q && ifAddr < 24'h024000; endsequence
  line_aligned_a: assert property (flashReq_q |-> flashAddr_q[5:0] == 6'h00)
    else $error("line fetch not aligned");
  req_hold_a: assert property (
    flashReq_q && !flashAck |=> flashReq_q && $stable(flashAddr_q))
    else $error("line request dropped early");
  fill_write_a: assert property (flashWordValid |=> cacheRamWe_q)
    else $error("flash word not stored");
  fill_answer_a: assert property (fillDone |-> answerSoon)
    else $error("no answer after line fill");
  rom_fetch_a: assert property (
    romTake |=> iTcmSel_q == 9'h001 && {4'h0, iTcmAddr_q} == $past(ifAddr))
    else $error("boot store fetch misrouted");
  periph_sel_a: assert property (
    dReq && dAddr[23:20] == 4'hF |=> periphSel_q && {4'hF, periphAddr_q} == $past(dAddr))
    else $error("peripheral access misrouted");
  unmapped_err_a: assert property (
    dReq && (dAddr[23:20] == 4'h1 || dAddr[23:20] == 4'hE) |=> dErr_q)
    else $error("unmapped access not refused");
  dir_locked_a: assert property (
    dReq && dWe && dAddr[23:20] == 4'hC && cacheActive_q |=> dErr_q)
    else $error("directory write while active");
  bank_excl_a: assert property (cacheActive_q |-> !dTcmSel_q[7] && !iTcmSel_q[8])
    else $error("cache bank used as memory");
  flash_random_a: assert property (cacheActive_q |-> !flashRandomAllow_q)
    else $error("random flash allowed with cache");
  window_off_a: assert property (
    ifReq && ifReady_q && ifAddr[23:22] == 2'h1 && !cacheActive_q |=> ifErr_q)
    else $error("window fetch with cache off");
  bank_power_a: assert property (
    $stable(bankCfg) ##1 $stable(bankCfg) |-> bankPowerOn_q == pwrExp)
    else $error("bank power mismatch");
endmodule
bind mbx_mem_cache mbx_mem_cache_assertions i_mbx_mem_cache_assertions (.*);

// ===== testbench/mbx_flash_model.sv
// Behavioural flash answering whole line fetches
`timescale 1ns/1ps
module mbx_flash_model (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Line request and pacing
  input wire flashReq_q,
  input wire [22:0] flashAddr_q,
  input wire slow,
  // Answer toward the cache
  output logic flashAck = 1'b0,
  output logic flashWordValid = 1'b0,
  output logic [31:0] flashWord = 32'h0
);
  logic [22:0] base; // Line being streamed
  // Each word equals its own byte address, so a misplaced word shows
  always begin
    @(posedge clk);
    if (rst_n && flashReq_q) begin
      base = flashAddr_q;
      #1 flashAck = 1'b1;
      @(posedge clk);
      #1 flashAck = 1'b0;
      for (int i = 0; i < 16; i++) begin
        // Slow mode drops the strobe and stalls between words
        if (slow) begin
          flashWordValid = 1'b0;
          flashWord = ~flashWord; // Stale value is never held
          repeat (2) @(posedge clk);
          #1;
        end
        // Fast mode keeps the strobe up, one word per edge
        flashWordValid = 1'b1;
        flashWord = {9'h000, base + 23'(4 * i)};
        @(posedge clk);
        #1;
      end
      flashWordValid = 1'b0;
      flashWord = ~flashWord;
    end
  end
endmodule

// ===== testbench/mbx_mem_cache_tb.sv
// Self-checking bench for the memory map and read cache
`timescale 1ns/1ps
module mbx_mem_cache_tb;
  // Stimulus, all given a value at time zero
  logic clk = 1'b0, rst_n = 1'b0, hostBootSelectPad = 1'b1, fwCacheEnable = 1'b0;
  logic ifReq = 1'b0, dReq = 1'b0, dWe = 1'b0, slow = 1'b0;
  logic [13:0] bankCfg = 14'h3009; // Bank0 instr, bank1 data, bank6 cache
  logic [23:0] ifAddr = 24'h0, dAddr = 24'h0;
  logic [31:0] dWdata = 32'h0, cacheRamRdata = 32'h0;
  // Design and partner outputs
  logic [31:0] flashWord, ifData_q, dRdata_q, dTcmWdata_q, cacheRamWdata_q;
  logic ifReady_q, ifValid_q, ifErr_q, dValid_q, dErr_q, dTcmWe_q, periphSel_q;
  logic cacheActive_q, flashRandomAllow_q, cacheRamRd_q, cacheRamWe_q;
  logic flashReq_q, flashAck, flashWordValid;
  logic [8:0] iTcmSel_q;
  logic [19:0] iTcmAddr_q, dTcmAddr_q, periphAddr_q;
  logic [7:0] dTcmSel_q;
  logic [6:0] bankPowerOn_q;
  logic [12:0] cacheRamAddr_q;
  logic [22:0] flashAddr_q, lastLine;
  logic [31:0] cram [0:8191]; // Cache storage bank
  int fail_count = 0, checked = 0, reqCnt = 0, k;
  mbx_mem_cache i_mbx_mem_cache (.*);
  mbx_flash_model i_mbx_flash_model (.*);
  initial forever #2 clk = ~clk;
  // Bank macro: data one cycle after the strobe, junk otherwise
  always @(posedge clk) begin
    if (cacheRamWe_q) cram[cacheRamAddr_q] <= cacheRamWdata_q;
    cacheRamRdata <= cacheRamRd_q ? cram[cacheRamAddr_q] : ~cacheRamRdata;
  end
  // Count accepted line fetches
  always @(posedge clk) begin
    if (flashReq_q && flashAck) begin
      reqCnt++;
      lastLine = flashAddr_q;
    end
  end
  task step;
    @(posedge clk);
    #1;
  endtask
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      fail_count++;
      $display("[ERR] %s exp %h seen %h", n, e, s);
    end
  endtask
  task report_and_stop;
    $display("checks %0d errors %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Fetch: hold until taken, then wait for any answer
  task fetch(input logic [23:0] a);
    int n;
    step; // Let an edge pass so a request is never re-raised in one time step
    ifReq = 1'b1;
    ifAddr = a;
    for (n = 0; n < 99 && ifReady_q !== 1'b1; n++) step;
    step;
    ifReq = 1'b0;
    k = 0;
    for (n = 0; n < 200 && k == 0; n++) begin
      if (ifValid_q === 1'b1) k = 1;
      else if (ifErr_q === 1'b1) k = 2;
      else if (|iTcmSel_q === 1'b1) k = 3;
      else step;
    end
    if (k == 0) begin
      chk("fetchTimeout", 0, 1);
      report_and_stop;
    end
  endtask
  // Data access: one taken edge, answer the cycle after
  task dacc(input logic we, input logic [23:0] a);
    step; // Gap edge between two accesses
    dReq = 1'b1;
    dWe = we;
    dAddr = a;
    step;
    dReq = 1'b0;
    dWe = 1'b0;
    k = 0;
    for (int n = 0; n < 3 && k == 0; n++) begin
      if (dValid_q === 1'b1) k = 1;
      else if (dErr_q === 1'b1) k = 2;
      else if (|dTcmSel_q === 1'b1) k = 3;
      else if (periphSel_q === 1'b1) k = 4;
      else step;
    end
  endtask
  task doReset(input logic strap);
    rst_n = 1'b0;
    hostBootSelectPad = strap;
    repeat (5) step;
    chk("rstReady", ifReady_q, 0);
    rst_n = 1'b1;
    repeat (3) step;
  endtask
  task tPower;
    chk("power", bankPowerOn_q, 7'h43);
    chk("hostBootOff", cacheActive_q, 0);
    chk("randomOk", flashRandomAllow_q, 1);
  endtask
  // Fetch map incl. ROM top, off bank, data area, window with cache off
  task tIfMap;
    logic [23:0] a [7] = '{24'h000100, 24'h023FFC, 24'h024010, 24'h028020,
                           24'h038000, 24'h200000, 24'h400000};
    logic [8:0] s [7] = '{9'h001, 9'h001, 9'h002, 9'h004, 9'h000, 9'h000, 9'h000};
    logic [19:0] o [4] = '{20'h00100, 20'h23FFC, 20'h00010, 20'h00020};
    for (int n = 0; n < 7; n++) begin
      fetch(a[n]);
      chk("ifKind", k, n < 4 ? 3 : 2);
      chk("ifSel", iTcmSel_q, s[n]);
      if (n < 4) chk("ifOff", iTcmAddr_q, o[n]);
    end
  endtask
  task tDMap;
    logic [23:0] a [6] = '{24'h200004, 24'h20C008, 24'hF00010, 24'h100000, 24'h400000, 24'h0};
    int t [6] = '{3, 3, 4, 2, 2, 2};
    logic [7:0] s [6] = '{8'h01, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [19:0] o [3] = '{20'h00004, 20'h00008, 20'h00010};
    for (int n = 0; n < 6; n++) begin
      dacc(1'b0, a[n]);
      chk("dKind", k, t[n]);
      chk("dSel", dTcmSel_q, s[n]);
      if (n < 3) chk("dOff", n == 2 ? periphAddr_q : dTcmAddr_q, o[n]);
    end
    dWdata = 32'h5A5A1234;
    dacc(1'b1, 24'h200008);
    chk("dWe", dTcmWe_q, 1);
    chk("dWdata", dTcmWdata_q, 32'h5A5A1234);
  endtask
  // Boot style invalidation of both ways, then read back
  task tDir;
    for (int n = 0; n < 512; n++) begin
      dacc(1'b1, 24'hC00000 | 24'(n << 2));
      chk("dirWr", k, 1);
    end
    dacc(1'b0, 24'hC00404);
    chk("dirRd", k, 1);
    chk("dirTag", dRdata_q, 32'h0);
  endtask
  task tEnable;
    bankCfg = 14'h2009;
    fwCacheEnable = 1'b1;
    repeat (3) step;
    chk("lastBankData", cacheActive_q, 0);
    dacc(1'b0, 24'h234000);
    chk("bank6Data", dTcmSel_q, 8'h80);
    bankCfg = 14'h3009;
    repeat (3) step;
    chk("fwOn", cacheActive_q, 1);
    chk("randomOff", flashRandomAllow_q, 0);
    dacc(1'b1, 24'hC00000);
    chk("dirLocked", k, 2);
    dacc(1'b0, 24'h234000);
    chk("bankDataOff", k, 2);
    fetch(24'h058000);
    chk("bankInstrOff", k, 2);
  endtask
  // Miss, hit, window top, then LRU on one set with a slow flash
  task tCache;
    logic [23:0] a [9] = '{24'h400048, 24'h40004C, 24'hBFFFF0, 24'h400000, 24'h404000,
                           24'h400000, 24'h408000, 24'h400000, 24'h404000};
    int m [9] = '{1, 0, 1, 1, 1, 0, 1, 0, 1};
    logic [23:0] fa;
    int r;
    for (int n = 0; n < 9; n++) begin
      slow = n > 2;
      r = reqCnt;
      fa = a[n] - 24'h400000;
      fetch(a[n]);
      chk("cKind", k, 1);
      chk("cData", ifData_q, {8'h00, fa});
      chk("cMiss", reqCnt - r, m[n]);
      if (m[n] == 1) chk("cLine", lastLine, fa[22:0] & 23'h7FFFC0);
    end
    // Set 1, way 1 holds tag 0 after the first miss; clear it with the cache off
    dacc(1'b0, 24'hC00404);
    chk("dirFilled", dRdata_q, 32'h00000200);
    fwCacheEnable = 1'b0;
    dacc(1'b1, 24'hC00404);
    chk("dirWrOff", k, 1);
    dacc(1'b0, 24'hC00404);
    chk("dirCleared", dRdata_q, 32'h00000000);
  endtask
  task tBoot;
    fwCacheEnable = 1'b0;
    doReset(1'b0);
    chk("strapOn", cacheActive_q, 1);
    chk("strapRandom", flashRandomAllow_q, 0);
  endtask
  initial begin
    doReset(1'b1);
    tPower;
    tIfMap;
    tDMap;
    tDir;
    tEnable;
    tCache;
    tBoot;
    report_and_stop;
  end
  initial begin
    #200000;
    fail_count++;
    report_and_stop;
  end
endmodule
